/* File: alm_device.sv */
// Monitor end: serial target, register set, alert logic, auto conversion.
// Assumes the link pins arrive asynchronously and sampleIn is synchronous.
//
// Contract
// - Master code 00001xxx is not acknowledged
// - Master raises speed, repeated start after it
// - Restart keeps high speed; stop ends it
// - Two three-level straps select target address
// - Strapless variant answers one fixed address
// - Each conversion compared against both limits
// - Over and under flags set independently
// - Flag enable forces result MSB on alert
// - Pin enable drives alert output active
// - Polarity zero active low, one high
// - Writing one clears the matching flag
// - Without hold, over clears below upper-hysteresis
// - Without hold, under clears above lower+hysteresis
// - Cleared while violating sets again next conversion
// - Only sampled conversion values raise alerts
// - Non-zero cycle field starts automatic conversions
// - Oscillator stays on in automatic mode
// - Auto results update result and alert state
// - Auto conversions update lowest and highest trackers
// - Write starts with pointer byte after address
// - Read uses retained pointer when none written
// - Read sends upper byte first, repeats on ack
// - Write acknowledges upper, lower, further pairs
`timescale 1ns/1ps
module alm_device
  import alm_pkg::*;
#(
  parameter bit HAS_STRAPS = 1'b1
)
(
  input wire logic clk,
  input wire logic rstn,
  alm_if.device bus,
  input wire logic [1:0] addrStrapLow,
  input wire logic [1:0] addrStrapHigh,
  input wire logic [11:0] sampleIn,
  output logic convDone,
  output logic oscOn,
  output logic alertOut,
  output logic hsActive
);
  alm_dev_state_type state;
  logic sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
  logic [3:0] strapS1, strapS2;
  logic [7:0] shreg, ptr, cfgReg, txByteHi, txByteLo;
  logic [3:0] bitCnt;
  logic sdaDrive, rwBit, firstByte, upperNext, masterAck, hsMode;
  logic [11:0] result, upperLimit, lowerLimit, hystValue;
  logic [11:0] lowestResult, highestResult;
  logic overFlag, underFlag;
  logic [15:0] autoCnt, autoPeriod, readWord;
  logic [6:0] targetAddr;
  logic sclRise, sclFall, startEv, stopEv, rxDone, wrUpper, wrLower;
  logic autoMode, autoTick, convTrig, addrHit, alertAct;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD} <= 6'h3F;
      strapS1 <= 4'h0;
      strapS2 <= 4'h0;
    end
    else
    begin
      sclS1 <= bus.scl;
      sclS2 <= sclS1;
      sclD <= sclS2;
      sdaS1 <= bus.sda;
      sdaS2 <= sdaS1;
      sdaD <= sdaS2;
      strapS1 <= {addrStrapHigh, addrStrapLow};
      strapS2 <= strapS1;
    end
  end

  assign sclRise = sclS2 && !sclD;
  assign sclFall = !sclS2 && sclD;
  assign startEv = sclS2 && sclD && sdaD && !sdaS2;
  assign stopEv = sclS2 && sclD && !sdaD && sdaS2;
  // Straps encode 0 floating, 1 ground, 2 supply
  assign targetAddr = HAS_STRAPS ?
    {5'(ADDR_BASE + {3'h0, strapS2[3:2]}), strapS2[1:0]} :
    FIXED_ADDR;
  assign addrHit = state == D_ADDR && bitCnt == 4'h8 &&
    shreg[7:1] == targetAddr;
  assign rxDone = sclFall && state == D_RX && bitCnt == 4'h8;
  assign wrUpper = rxDone && !firstByte && upperNext;
  assign wrLower = rxDone && !firstByte && !upperNext;
  assign autoMode = cfgReg[7:CFG_CYCLE_LSB] != 3'h0;
  assign autoPeriod = 16'(CONV_BASE_CYC) << (cfgReg[7:CFG_CYCLE_LSB] - 3'h1);
  assign autoTick = autoMode && autoCnt == 16'h0000;
  // A manual conversion is taken when a read addresses the device with the pointer at the result register, outside automatic mode
  assign convTrig = autoTick || (sclFall && addrHit && shreg[0] &&
    ptr == PTR_RESULT && !autoMode);
  assign alertAct = overFlag || underFlag;
  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe = sdaDrive;

  always_comb
  begin
    case (ptr)
      PTR_RESULT: readWord = {cfgReg[CFG_FLAG_EN] && alertAct, 3'h0,
        result};
      PTR_STATUS: readWord = {6'h00, overFlag, underFlag, 8'h00};
      PTR_CONFIG: readWord = {cfgReg, 8'h00};
      PTR_LOWER: readWord = {4'h0, lowerLimit};
      PTR_UPPER: readWord = {4'h0, upperLimit};
      PTR_HYST: readWord = {4'h0, hystValue};
      PTR_LOWEST: readWord = {4'h0, lowestResult};
      PTR_HIGHEST: readWord = {4'h0, highestResult};
      default: readWord = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= D_IDLE;
      shreg <= 8'h00;
      bitCnt <= 4'h0;
      sdaDrive <= 1'b0;
      rwBit <= 1'b0;
      firstByte <= 1'b0;
      upperNext <= 1'b0;
      masterAck <= 1'b0;
      txByteHi <= 8'h00;
      txByteLo <= 8'h00;
      hsMode <= 1'b0;
    end
    else if (startEv)
    begin
      state <= D_ADDR;
      bitCnt <= 4'h0;
      sdaDrive <= 1'b0;
    end
    else if (stopEv)
    begin
      state <= D_IDLE;
      sdaDrive <= 1'b0;
      hsMode <= 1'b0;
    end
    else if (sclRise)
    begin
      case (state)
        D_ADDR, D_RX:
        begin
          shreg <= {shreg[6:0], sdaS2};
          bitCnt <= bitCnt + 4'h1;
        end
        D_TX: bitCnt <= bitCnt + 4'h1;
        D_TX_ACK: masterAck <= !sdaS2;
        default: ;
      endcase
    end
    else if (sclFall)
    begin
      case (state)
        D_ADDR:
          if (bitCnt == 4'h8)
          begin
            if (shreg[7:3] == HS_CODE)
            begin
              hsMode <= 1'b1;
              state <= D_IDLE;
            end
            else if (addrHit)
            begin
              sdaDrive <= 1'b1;
              rwBit <= shreg[0];
              state <= D_ADDR_ACK;
            end
            else
              state <= D_IDLE;
          end
        D_ADDR_ACK:
        begin
          bitCnt <= 4'h0;
          if (rwBit)
          begin
            txByteHi <= readWord[15:8];
            txByteLo <= readWord[7:0];
            shreg <= readWord[15:8];
            sdaDrive <= !readWord[15];
            upperNext <= 1'b0;
            state <= D_TX;
          end
          else
          begin
            sdaDrive <= 1'b0;
            firstByte <= 1'b1;
            state <= D_RX;
          end
        end
        D_RX:
          if (bitCnt == 4'h8)
          begin
            sdaDrive <= 1'b1;
            state <= D_RX_ACK;
          end
        D_RX_ACK:
        begin
          sdaDrive <= 1'b0;
          bitCnt <= 4'h0;
          firstByte <= 1'b0;
          upperNext <= firstByte || !upperNext;
          state <= D_RX;
        end
        D_TX:
          if (bitCnt == 4'h8)
          begin
            sdaDrive <= 1'b0;
            state <= D_TX_ACK;
          end
          else
          begin
            shreg <= {shreg[6:0], 1'b0};
            sdaDrive <= !shreg[6];
          end
        D_TX_ACK:
          if (masterAck)
          begin
            bitCnt <= 4'h0;
            shreg <= upperNext ? txByteHi : txByteLo;
            sdaDrive <= upperNext ? !txByteHi[7] : !txByteLo[7];
            upperNext <= !upperNext;
            state <= D_TX;
          end
          else
            state <= D_IDLE;
        default: state <= D_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ptr <= PTR_RESULT;
      cfgReg <= CONFIG_RST;
      upperLimit <= UPPER_RST;
      lowerLimit <= LOWER_RST;
      hystValue <= HYST_RST;
    end
    else
    begin
      if (rxDone && firstByte)
        ptr <= shreg;
      if (wrUpper && ptr == PTR_CONFIG)
        cfgReg <= shreg;
      if (wrUpper && ptr == PTR_UPPER)
        upperLimit[11:8] <= shreg[3:0];
      if (wrLower && ptr == PTR_UPPER)
        upperLimit[7:0] <= shreg;
      if (wrUpper && ptr == PTR_LOWER)
        lowerLimit[11:8] <= shreg[3:0];
      if (wrLower && ptr == PTR_LOWER)
        lowerLimit[7:0] <= shreg;
      if (wrUpper && ptr == PTR_HYST)
        hystValue[11:8] <= shreg[3:0];
      if (wrLower && ptr == PTR_HYST)
        hystValue[7:0] <= shreg;
    end
  end

  // Conversion result and alert flags; a conversion set beats a write clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      result <= 12'h000;
      overFlag <= 1'b0;
      underFlag <= 1'b0;
    end
    else
    begin
      if (wrUpper && ptr == PTR_STATUS && shreg[ST_OVER])
        overFlag <= 1'b0;
      if (wrUpper && ptr == PTR_STATUS && shreg[ST_UNDER])
        underFlag <= 1'b0;
      if (convTrig)
      begin
        result <= sampleIn;
        if (sampleIn > upperLimit)
          overFlag <= 1'b1;
        else if (!cfgReg[CFG_HOLD] &&
          {1'b0, sampleIn} + {1'b0, hystValue} < {1'b0, upperLimit})
          overFlag <= 1'b0;
        if (sampleIn < lowerLimit)
          underFlag <= 1'b1;
        else if (!cfgReg[CFG_HOLD] &&
          {1'b0, sampleIn} > {1'b0, lowerLimit} + {1'b0, hystValue})
          underFlag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lowestResult <= LOWEST_RST;
      highestResult <= HIGHEST_RST;
    end
    else
    begin
      if (autoTick && sampleIn < lowestResult)
        lowestResult <= sampleIn;
      if (autoTick && sampleIn > highestResult)
        highestResult <= sampleIn;
      if (wrUpper && ptr == PTR_LOWEST)
        lowestResult[11:8] <= shreg[3:0];
      if (wrLower && ptr == PTR_LOWEST)
        lowestResult[7:0] <= shreg;
      if (wrUpper && ptr == PTR_HIGHEST)
        highestResult[11:8] <= shreg[3:0];
      if (wrLower && ptr == PTR_HIGHEST)
        highestResult[7:0] <= shreg;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      autoCnt <= 16'h0000;
    else if (!autoMode)
      autoCnt <= 16'h0000;
    else if (autoTick)
      autoCnt <= autoPeriod - 16'h0001;
    else
      autoCnt <= autoCnt - 16'h0001;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      convDone <= 1'b0;
      oscOn <= 1'b0;
      alertOut <= 1'b1;
      hsActive <= 1'b0;
    end
    else
    begin
      convDone <= convTrig;
      oscOn <= autoMode;
      alertOut <= cfgReg[CFG_POL] ==
        (cfgReg[CFG_PIN_EN] && alertAct);
      hsActive <= hsMode;
    end
  end
endmodule

/* File: alm_pkg.sv */
// Shared constants of the limit-alert monitor: timing, pointers, fields.
// Assumes a 50 MHz system clock on both ends.
package alm_pkg;
  localparam int SYS_CLK_NS = 20;
  localparam int SCL_SF_NS = 2500;
  localparam int SCL_HS_NS = 320;
  localparam int QUARTER_SF_CYC =
    (SCL_SF_NS + 4 * SYS_CLK_NS - 1) / (4 * SYS_CLK_NS);
  localparam int QUARTER_HS_CYC =
    (SCL_HS_NS + 4 * SYS_CLK_NS - 1) / (4 * SYS_CLK_NS);
  localparam int CONV_BASE_NS = 1280;
  localparam int CONV_BASE_CYC =
    (CONV_BASE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_STATUS = 8'h01;
  localparam logic [7:0] PTR_CONFIG = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_UPPER = 8'h04;
  localparam logic [7:0] PTR_HYST = 8'h05;
  localparam logic [7:0] PTR_LOWEST = 8'h06;
  localparam logic [7:0] PTR_HIGHEST = 8'h07;

  localparam int CFG_CYCLE_LSB = 5;
  localparam int CFG_HOLD = 4;
  localparam int CFG_FLAG_EN = 3;
  localparam int CFG_PIN_EN = 2;
  localparam int CFG_POL = 0;
  localparam int ST_UNDER = 0;
  localparam int ST_OVER = 1;

  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [11:0] UPPER_RST = 12'hFFF;
  localparam logic [11:0] LOWER_RST = 12'h000;
  localparam logic [11:0] HYST_RST = 12'h000;
  localparam logic [11:0] LOWEST_RST = 12'hFFF;
  localparam logic [11:0] HIGHEST_RST = 12'h000;

  localparam logic [4:0] HS_CODE = 5'h01;
  localparam logic [7:0] HS_MASTER_BYTE = 8'h08;
  localparam logic [4:0] ADDR_BASE = 5'h14;
  localparam logic [6:0] FIXED_ADDR = 7'h54;

  localparam logic [2:0] HOST_CTRL = 3'h0;
  localparam logic [2:0] HOST_TARGET = 3'h1;
  localparam logic [2:0] HOST_PTR = 3'h2;
  localparam logic [2:0] HOST_WDATA = 3'h3;
  localparam logic [2:0] HOST_RDATA = 3'h4;
  localparam logic [2:0] HOST_STATUS = 3'h5;
  localparam int CTRL_READ = 0;
  localparam int CTRL_PTR = 1;
  localparam int CTRL_HS = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;

  localparam logic [3:0] SLOT_START = 4'h0;
  localparam logic [3:0] SLOT_HS_CODE = 4'h1;
  localparam logic [3:0] SLOT_HS_RESTART = 4'h2;
  localparam logic [3:0] SLOT_ADDR_W = 4'h3;
  localparam logic [3:0] SLOT_PTR = 4'h4;
  localparam logic [3:0] SLOT_DATA_HI = 4'h5;
  localparam logic [3:0] SLOT_DATA_LO = 4'h6;
  localparam logic [3:0] SLOT_RESTART = 4'h7;
  localparam logic [3:0] SLOT_ADDR_R = 4'h8;
  localparam logic [3:0] SLOT_READ_HI = 4'h9;
  localparam logic [3:0] SLOT_READ_LO = 4'hA;
  localparam logic [3:0] SLOT_STOP = 4'hB;

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_ADDR_ACK, D_RX, D_RX_ACK, D_TX, D_TX_ACK
  } alm_dev_state_type;
endpackage

/* File: alm_if.sv */
// Two-wire link between controller and monitor, open-drain resolved here.
// Assumes pull-ups: a line is high unless some end enables a low drive.
`timescale 1ns/1ps
interface alm_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;

  assign scl = !(hostSclOe && !hostSclOut);
  assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

  modport device (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (input scl, input sda, output hostSclOut, output hostSclOe,
    output hostSdaOut, output hostSdaOe);
endinterface

/* File: alm_host.sv */
// Controller end: runs whole transfers ordered through a small register port.
// Assumes it alone drives the clock line; the data line is open drain.
`timescale 1ns/1ps
module alm_host
  import alm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  alm_if.host bus
);
  logic [2:0] ctrl;
  logic [6:0] target;
  logic [7:0] ptrVal, slotByte, rxSh;
  logic [15:0] wdata, rdata;
  logic busy, nackErr, hsNow, sclLow, sdaLow, ackOk, sdaS1, sdaS2;
  logic [3:0] slot, bitCnt, nextSlot;
  logic [1:0] q;
  logic [7:0] tick;
  logic [11:0] en;
  logic isCond, isStop, isRead, lastBit, bitVal;

  assign bus.hostSclOut = 1'b0;
  assign bus.hostSclOe = sclLow;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOe = sdaLow;

  // Slots of the fixed template that this transfer uses
  assign en = {1'b1, {3{ctrl[CTRL_READ]}},
    ctrl[CTRL_READ] && ctrl[CTRL_PTR], {2{!ctrl[CTRL_READ]}},
    {2{ctrl[CTRL_PTR] || !ctrl[CTRL_READ]}}, {2{ctrl[CTRL_HS]}}, 1'b1};
  assign isCond = slot == SLOT_START || slot == SLOT_HS_RESTART ||
    slot == SLOT_RESTART;
  assign isStop = slot == SLOT_STOP;
  assign isRead = slot == SLOT_READ_HI || slot == SLOT_READ_LO;
  assign lastBit = isCond || isStop || bitCnt == 4'h8;
  assign bitVal = bitCnt == 4'h8 ? slot != SLOT_READ_HI :
    (isRead || slotByte[3'h7 - bitCnt[2:0]]);

  always_comb
  begin
    nextSlot = SLOT_STOP;
    for (int i = 11; i >= 0; i--)
      if (4'(i) > slot && en[i])
        nextSlot = 4'(i);
    case (slot)
      SLOT_HS_CODE: slotByte = HS_MASTER_BYTE;
      SLOT_ADDR_W: slotByte = {target, 1'b0};
      SLOT_PTR: slotByte = ptrVal;
      SLOT_DATA_HI: slotByte = wdata[15:8];
      SLOT_DATA_LO: slotByte = wdata[7:0];
      SLOT_ADDR_R: slotByte = {target, 1'b1};
      default: slotByte = 8'hFF;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      target <= 7'h00;
      ptrVal <= 8'h00;
      wdata <= 16'h0000;
      regRdata <= 16'h0000;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
    end
    else
    begin
      sdaS1 <= bus.sda;
      sdaS2 <= sdaS1;
      if (regWr && !busy && regAddr == HOST_TARGET)
        target <= regWdata[6:0];
      if (regWr && !busy && regAddr == HOST_PTR)
        ptrVal <= regWdata[7:0];
      if (regWr && !busy && regAddr == HOST_WDATA)
        wdata <= regWdata;
      if (regRd)
        case (regAddr)
          HOST_CTRL: regRdata <= {13'h0000, ctrl};
          HOST_TARGET: regRdata <= {9'h000, target};
          HOST_PTR: regRdata <= {8'h00, ptrVal};
          HOST_WDATA: regRdata <= wdata;
          HOST_RDATA: regRdata <= rdata;
          HOST_STATUS: regRdata <= {14'h0000, nackErr, busy};
          default: regRdata <= 16'h0000;
        endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= 3'h0;
      busy <= 1'b0;
      nackErr <= 1'b0;
      rdata <= 16'h0000;
      hsNow <= 1'b0;
      sclLow <= 1'b0;
      sdaLow <= 1'b0;
      ackOk <= 1'b0;
      rxSh <= 8'h00;
      slot <= SLOT_START;
      bitCnt <= 4'h0;
      q <= 2'h0;
      tick <= 8'h00;
    end
    else if (!busy)
    begin
      hsNow <= 1'b0;
      if (regWr && regAddr == HOST_CTRL)
      begin
        ctrl <= regWdata[2:0];
        busy <= 1'b1;
        nackErr <= 1'b0;
        slot <= SLOT_START;
        bitCnt <= 4'h0;
        q <= 2'h0;
        tick <= 8'h00;
      end
    end
    else if (tick != 8'h00)
      tick <= tick - 8'h01;
    else
    begin
      tick <= hsNow ? 8'(QUARTER_HS_CYC - 1) : 8'(QUARTER_SF_CYC - 1);
      q <= q + 2'h1;
      case (q)
        2'h0: sdaLow <= isStop || (!isCond && !bitVal);
        2'h1: sclLow <= 1'b0;
        2'h2:
          if (isCond || isStop)
            sdaLow <= isCond;
          else if (bitCnt == 4'h8)
            ackOk <= !sdaS2;
          else if (isRead)
            rxSh <= {rxSh[6:0], sdaS2};
        default:
        begin
          sclLow <= !isStop;
          bitCnt <= lastBit ? 4'h0 : bitCnt + 4'h1;
          if (lastBit && isStop)
            busy <= 1'b0;
          else if (lastBit && !isCond && !isRead && !ackOk &&
            slot != SLOT_HS_CODE)
          begin
            nackErr <= 1'b1;
            slot <= SLOT_STOP;
          end
          else if (lastBit)
            slot <= nextSlot;
          if (lastBit && slot == SLOT_HS_CODE)
            hsNow <= 1'b1;
          if (lastBit && slot == SLOT_READ_HI)
            rdata[15:8] <= rxSh;
          if (lastBit && slot == SLOT_READ_LO)
            rdata[7:0] <= rxSh;
        end
      endcase
    end
  end
endmodule

/* File: alm_checker.sv */
// Assertions on the two-wire link and the monitor's status outputs.
// Assumes one clk domain; the bench places it beside the link.
`timescale 1ns/1ps
module alm_checker
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSdaOe,
  input wire logic hsActive,
  input wire logic convDone,
  input wire logic oscOn
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [12:0] gap;
  logic [3:0] stopAge;
  logic prevSda;
  logic lastAuto;

  // Cycles since the last conversion pulse
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      gap <= 13'h0000;
    else if (convDone)
      gap <= 13'h0000;
    else if (gap != 13'h1FFF)
      gap <= gap + 13'h0001;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      prevSda <= 1'b1;
    else
      prevSda <= sda;

  // Cycles since a stop seen on the raw lines
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      stopAge <= 4'hF;
    else if (scl && sda && !prevSda)
      stopAge <= 4'h0;
    else if (stopAge != 4'hF)
      stopAge <= stopAge + 4'h1;

  // Previous conversion was an automatic one and the mode never paused
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      lastAuto <= 1'b0;
    else if (convDone)
      lastAuto <= oscOn;
    else if (!oscOn)
      lastAuto <= 1'b0;

  conv_pulse_a: assert property (convDone |=> !convDone)
    else $error("conversion pulse too long");
  auto_first_a: assert property ($rose(oscOn) |-> ##[0:3] convDone)
    else $error("no conversion after auto start");
  auto_gap_a: assert property (convDone && lastAuto && oscOn |->
    gap inside {13'h003F, 13'h007F, 13'h00FF, 13'h01FF, 13'h03FF,
    13'h07FF, 13'h0FFF})
    else $error("auto conversion period wrong");
  hs_nack_a: assert property ($rose(hsActive) |-> !devSdaOe [*8])
    else $error("master code acknowledged");
  hs_stop_a: assert property (scl && sda && !prevSda |->
    ##[1:8] !hsActive)
    else $error("high speed kept after stop");
  hs_keep_a: assert property ($fell(hsActive) |-> stopAge < 4'hC)
    else $error("high speed left without stop");
  dev_drive_a: assert property ($rose(devSdaOe) |-> !scl)
    else $error("data driven while clock high");
  dev_release_a: assert property ($fell(devSdaOe) |-> !scl)
    else $error("data released while clock high");
endmodule

/* File: alm_tb.sv */
// Bench joining controller and monitor over the link, host port driven.
// Assumes the package's timing constants and a 50 MHz clock.
`timescale 1ns/1ps
module alm_tb import alm_pkg::*; ;
  logic clk, rstn, regWr, regRd, convDone, oscOn, alertOut, hsActive;
  logic [2:0] regAddr;
  logic [15:0] regWdata, regRdata, q;
  logic [1:0] strapLo, strapHi;
  logic [11:0] sampleIn, cur, mn, mx, up, lo, hy;
  logic [11:0] cs[8] = '{12'h900, 12'h7F0, 12'h7B0, 12'h800, 12'h0FF,
    12'h140, 12'h141, 12'h7FF};
  logic [7:0] cf;
  logic [6:0] tgt;
  logic ov, un, expNak;
  int seed, bad_count, comparisons, hsCount, k, n;

  alm_if alm_if_inst();
  alm_device alm_device_inst (.clk(clk), .rstn(rstn), .bus(alm_if_inst),
    .addrStrapLow(strapLo), .addrStrapHigh(strapHi), .sampleIn(sampleIn),
    .convDone(convDone), .oscOn(oscOn), .alertOut(alertOut),
    .hsActive(hsActive));
  alm_host alm_host_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .bus(alm_if_inst));
  alm_checker alm_checker_inst (.clk(clk), .rstn(rstn),
    .scl(alm_if_inst.scl), .sda(alm_if_inst.sda),
    .devSdaOe(alm_if_inst.devSdaOe), .hsActive(hsActive),
    .convDone(convDone), .oscOn(oscOn));

  always #10 clk = ~clk;
  always @(posedge clk)
    if (hsActive === 1'b1)
      hsCount <= hsCount + 1;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One register access; a read returns the word standing the next cycle
  task automatic acc(input bit w, input logic [2:0] a,
    input logic [15:0] d, output logic [15:0] r);
    regAddr <= a;
    regWdata <= d;
    regWr <= w;
    regRd <= !w;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 r = regRdata;
    @(posedge clk);
  endtask

  // Whole link transfer; c is the control word, r the read word
  task automatic xfer(input logic [7:0] p, input logic [15:0] d,
    input logic [2:0] c, output logic [15:0] r);
    logic [15:0] s;
    int h;
    int i;
    h = hsCount;
    acc(1'b1, HOST_TARGET, {9'h000, tgt}, s);
    acc(1'b1, HOST_PTR, {8'h00, p}, s);
    acc(1'b1, HOST_WDATA, d, s);
    acc(1'b1, HOST_CTRL, {13'h0000, c}, s);
    s = 16'h0001;
    i = 0;
    while (s[STAT_BUSY] !== 1'b0 && i < 5000)
    begin
      acc(1'b0, HOST_STATUS, 16'h0000, s);
      i++;
    end
    chk(s, {14'h0000, expNak, 1'b0});
    acc(1'b0, HOST_RDATA, 16'h0000, r);
    chk({14'h0000, hsActive, hsCount != h}, {15'h0000, c[2]});
    chk({14'h0000, alm_if_inst.scl, alm_if_inst.sda}, 16'h0003);
  endtask

  task automatic devw(input logic [7:0] p, input logic [15:0] d);
    xfer(p, d, 3'h4, q);
  endtask

  // Flag model after one conversion of s
  function automatic void upd(input logic [11:0] s);
    ov = s > up || (ov && (cf[CFG_HOLD] || {1'b0, s} + hy >= up));
    un = s < lo || (un && (cf[CFG_HOLD] || s <= {1'b0, lo} + hy));
  endfunction

  function automatic logic alx();
    return (cf[CFG_PIN_EN] & (ov | un)) ~^ cf[CFG_POL];
  endfunction

  task automatic step(input logic [11:0] s);
    sampleIn <= s;
    upd(s);
    xfer(PTR_RESULT, 16'h0000, 3'h7, q);
    chk(q, {cf[CFG_FLAG_EN] & (ov | un), 3'h0, s});
    xfer(PTR_STATUS, 16'h0000, 3'h7, q);
    chk({8'h00, q[15:8]}, {14'h0000, ov, un});
    chk({15'h0000, alertOut}, {15'h0000, alx()});
  endtask

  initial
  begin
    #1950000;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    regAddr = 3'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    seed = 23;
    strapLo = 2'(($random(seed) & 32'h7FFF) % 3);
    strapHi = 2'(($random(seed) & 32'h7FFF) % 3);
    sampleIn = 12'h123;
    bad_count = 0;
    comparisons = 0;
    hsCount = 0;
    ov = 1'b0;
    un = 1'b0;
    up = UPPER_RST;
    lo = LOWER_RST;
    hy = HYST_RST;
    cf = CONFIG_RST;
    tgt = {ADDR_BASE + {3'h0, strapHi}, 2'h3};
    expNak = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    xfer(PTR_RESULT, 16'h0000, 3'h7, q);
    tgt[1:0] = strapLo;
    expNak = 1'b0;
    xfer(PTR_UPPER, 16'h0000, 3'h7, q);
    chk(q, {4'h0, UPPER_RST});
    xfer(PTR_LOWEST, 16'h0000, 3'h7, q);
    chk(q, {4'h0, LOWEST_RST});
    xfer(PTR_UPPER, 16'h0000, 3'h1, q);
    chk(q, {4'h0, LOWEST_RST});
    up = 12'h800;
    lo = 12'h100;
    hy = 12'h040;
    cf = 8'h0C;
    devw(PTR_UPPER, {4'h0, up});
    devw(PTR_LOWER, {4'h0, lo});
    devw(PTR_HYST, {4'h0, hy});
    devw(PTR_CONFIG, {cf, 8'h00});
    foreach (cs[i])
      step(cs[i]);
    step(12'($random(seed)));
    cf = 8'h1C;
    devw(PTR_CONFIG, {cf, 8'h00});
    step(12'h0FF);
    step(12'h300);
    devw(PTR_STATUS, 16'h0100);
    un = 1'b0;
    xfer(PTR_STATUS, 16'h0000, 3'h7, q);
    chk({8'h00, q[15:8]}, {14'h0000, ov, 1'b0});
    step(12'h0FF);
    cf = 8'h1D;
    devw(PTR_CONFIG, {cf, 8'h00});
    chk({15'h0000, alertOut}, {15'h0000, alx()});
    // Automatic mode: new input only right after a conversion
    cf = 8'h2C;
    cur = sampleIn;
    mn = cur;
    mx = cur;
    devw(PTR_CONFIG, {cf, 8'h00});
    for (k = 0; k < 12; k++)
    begin
      n = 0;
      while (convDone !== 1'b1 && n < 300)
      begin
        @(posedge clk);
        n++;
      end
      chk({14'h0000, oscOn, convDone}, 16'h0003);
      upd(cur);
      mn = cur < mn ? cur : mn;
      mx = cur > mx ? cur : mx;
      cur = 12'($random(seed));
      sampleIn <= cur;
      @(posedge clk);
    end
    upd(cur);
    mn = cur < mn ? cur : mn;
    mx = cur > mx ? cur : mx;
    cf = 8'h0C;
    devw(PTR_CONFIG, {cf, 8'h00});
    chk({15'h0000, oscOn}, 16'h0000);
    xfer(PTR_STATUS, 16'h0000, 3'h7, q);
    chk({8'h00, q[15:8]}, {14'h0000, ov, un});
    chk({15'h0000, alertOut}, {15'h0000, alx()});
    xfer(PTR_LOWEST, 16'h0000, 3'h7, q);
    chk(q, {4'h0, mn});
    xfer(PTR_HIGHEST, 16'h0000, 3'h7, q);
    chk(q, {4'h0, mx});
    give_verdict();
  end
endmodule
